/* File: hdl/sto_map.svh */
// Register offsets, field positions, reset values and timing counts of the torque off monitor
`ifndef STO_MAP_SVH
`define STO_MAP_SVH
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_IRQ_STATUS 12'h008
`define REG_IRQ_CLEAR 12'h00C
`define REG_IRQ_ENABLE 12'h010
`define FUNC_MONITOR 8'h15
`define FUNC_MONITOR_INV 8'h79
`define CTRL_RESET 32'h0000_0015
`define STOP_TIME_NS 3000000
`define MONITOR_TIME_NS 30000000
`define FILTER_TIME_NS 100000
`define CLOCK_PERIOD_NS 10
`define FILTER_CYCLES (`FILTER_TIME_NS / `CLOCK_PERIOD_NS)
`define IRQ_TORQUE_OFF 0
`define IRQ_MISMATCH 1
`define IRQ_RELEASE 2
`define IRQ_BAD_FUNC 3
`endif

/* File: hdl/sto_pkg.sv */
// Types of the torque off monitor
package sto_pkg;
	typedef enum logic [1:0] {ST_RUN_ALLOWED, ST_TORQUE_OFF, ST_WAIT_RELEASE} sto_state_type;
endpackage

/* File: hdl/safety_input_filter.sv */
// Synchroniser and stability filter for one safety input channel
`timescale 1ns/1ps
module safety_input_filter #(
	parameter int FILTER_CYCLES = 10000
) (
	// Clock, reset and enable
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic enable_i,
	// Pin and filtered level
	input wire logic pin_i,
	output logic closed_o
);
	logic sync_first;
	logic sync_second;
	logic [31:0] count;

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sync_first <= 1'b0;
			sync_second <= 1'b0;
		end
		else if (enable_i)
		begin
			sync_first <= pin_i;
			sync_second <= sync_first;
		end
	end

	// Opening is taken at once; closing must stay stable for the filter time
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			count <= 32'h0000_0000;
			closed_o <= 1'b0;
		end
		else if (enable_i)
		begin
			if (!sync_second)
			begin
				count <= 32'h0000_0000;
				closed_o <= 1'b0;
			end
			else if (count >= 32'(FILTER_CYCLES - 1))
				closed_o <= 1'b1;
			else
				count <= count + 32'h0000_0001;
		end
	end
endmodule // safety_input_filter

/* File: hdl/torque_off_monitor.sv */
// Dual channel safe torque off monitor with AXI4-Lite registers
`timescale 1ns/1ps
`include "sto_map.svh"
module torque_off_monitor
	import sto_pkg::*;
#(
	parameter int FILTER_CYCLES = `FILTER_CYCLES
) (
	// Clock, reset, enable
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic clock_enable_i,
	// Safety pins, high while closed
	input wire logic safety_input_a_i,
	input wire logic safety_input_b_i,
	// Drive control
	input wire logic run_command_i,
	output logic gate_enable_o,
	output logic torque_off_state_o,
	output logic channel_mismatch_fault_o,
	output logic multifunction_digital_output_o,
	output logic irq_o,
	// AXI4-Lite write
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic closed_a;
	logic closed_b;
	logic run_sync_first;
	logic run_sync;
	sto_state_type state;
	logic [7:0] output_function_select;
	logic [3:0] irq_status;
	logic [3:0] irq_enable;
	logic [3:0] event_set;
	logic [3:0] clear_pulse;
	logic prev_torque_off;
	logic prev_mismatch;
	logic [11:0] aw_addr;
	logic aw_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_held;
	logic do_write;
	logic [1:0] next_bresp;
	logic any_open;
	logic both_open;
	logic mismatch;
	logic func_valid;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] result;
		result = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				result[i*8 +: 8] = data[i*8 +: 8];
		return result;
	endfunction

	safety_input_filter #(.FILTER_CYCLES(FILTER_CYCLES)) filter_a (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.enable_i(clock_enable_i),
		.pin_i(safety_input_a_i),
		.closed_o(closed_a)
	);

	safety_input_filter #(.FILTER_CYCLES(FILTER_CYCLES)) filter_b (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.enable_i(clock_enable_i),
		.pin_i(safety_input_b_i),
		.closed_o(closed_b)
	);

	assign any_open = !closed_a || !closed_b;
	assign both_open = !closed_a && !closed_b;
	assign mismatch = closed_a != closed_b;
	assign func_valid = output_function_select == `FUNC_MONITOR || output_function_select == `FUNC_MONITOR_INV;

	// Run command comes from a terminal, so it is synchronised too
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			run_sync_first <= 1'b0;
			run_sync <= 1'b0;
		end
		else if (clock_enable_i)
		begin
			run_sync_first <= run_command_i;
			run_sync <= run_sync_first;
		end
	end

	// Starts in torque off so a power-up with run held does not start the motor
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			state <= ST_TORQUE_OFF;
		else if (clock_enable_i)
		begin
			case (state)
				ST_RUN_ALLOWED:
					if (any_open)
						state <= ST_TORQUE_OFF;
				ST_TORQUE_OFF:
					if (!any_open)
						state <= ST_WAIT_RELEASE;
				ST_WAIT_RELEASE:
					if (any_open)
						state <= ST_TORQUE_OFF;
					else if (!run_sync)
						state <= ST_RUN_ALLOWED;
				default:
					state <= ST_TORQUE_OFF;
			endcase
		end
	end

	// Gate cut the cycle after the filter reports open, ignoring stop method
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			gate_enable_o <= 1'b0;
			torque_off_state_o <= 1'b1;
			channel_mismatch_fault_o <= 1'b0;
			multifunction_digital_output_o <= 1'b0;
		end
		else if (clock_enable_i)
		begin
			gate_enable_o <= state == ST_RUN_ALLOWED && !any_open && run_sync;
			torque_off_state_o <= state != ST_RUN_ALLOWED || any_open;
			channel_mismatch_fault_o <= mismatch;
			if (output_function_select == `FUNC_MONITOR_INV)
				multifunction_digital_output_o <= !both_open;
			else if (output_function_select == `FUNC_MONITOR)
				multifunction_digital_output_o <= both_open;
			else
				multifunction_digital_output_o <= 1'b0;
		end
	end

	// Event detection for interrupts
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			prev_torque_off <= 1'b1;
			prev_mismatch <= 1'b0;
		end
		else if (clock_enable_i)
		begin
			prev_torque_off <= any_open;
			prev_mismatch <= mismatch;
		end
	end

	always_comb
	begin
		event_set = 4'h0;
		event_set[`IRQ_TORQUE_OFF] = any_open && !prev_torque_off;
		event_set[`IRQ_MISMATCH] = mismatch && !prev_mismatch;
		event_set[`IRQ_RELEASE] = state == ST_WAIT_RELEASE && !any_open && !run_sync;
		event_set[`IRQ_BAD_FUNC] = !func_valid;
	end

	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign clear_pulse = (do_write && aw_addr == `REG_IRQ_CLEAR) ? w_data[3:0] & {4{w_strb[0]}} : 4'h0;

	// A new event in the clearing cycle keeps its bit
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			irq_status <= 4'h0;
		else if (clock_enable_i)
			irq_status <= (irq_status & ~clear_pulse) | event_set;
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else if (clock_enable_i)
			irq_o <= |(irq_status & irq_enable);
	end

	// Write channel: address and data accepted in either order
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end
		else if (clock_enable_i)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= next_bresp;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_comb
	begin
		case (aw_addr)
			`REG_CTRL, `REG_IRQ_CLEAR, `REG_IRQ_ENABLE:
				next_bresp = 2'b00;
			`REG_STATUS, `REG_IRQ_STATUS:
				next_bresp = 2'b00;
			default:
				next_bresp = 2'b10;
		endcase
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end
		else if (clock_enable_i)
		begin
			s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
		end
	end

	// Control registers
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			output_function_select <= 8'(`CTRL_RESET);
			irq_enable <= 4'h0;
		end
		else if (clock_enable_i && do_write)
		begin
			if (aw_addr == `REG_CTRL)
				output_function_select <= 8'(merge_bytes({24'h00_0000, output_function_select}, w_data, w_strb));
			if (aw_addr == `REG_IRQ_ENABLE)
				irq_enable <= 4'(merge_bytes({28'h000_0000, irq_enable}, w_data, w_strb));
		end
	end

	// Read channel, one cycle after address
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end
		else if (clock_enable_i)
		begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				case (s_axi_araddr)
					`REG_CTRL: s_axi_rdata <= {24'h00_0000, output_function_select};
					`REG_STATUS: s_axi_rdata <= {25'h000_0000, run_sync, state, mismatch, torque_off_state_o,
						closed_b, closed_a};
					`REG_IRQ_STATUS: s_axi_rdata <= {28'h000_0000, irq_status};
					`REG_IRQ_ENABLE: s_axi_rdata <= {28'h000_0000, irq_enable};
					`REG_IRQ_CLEAR: s_axi_rdata <= 32'h0000_0000;
					default:
					begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= 2'b10;
					end
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule // torque_off_monitor

/* File: tb/torque_off_monitor_sva.sv */
// Port assertions for the torque off monitor
`timescale 1ns/1ps
module torque_off_monitor_sva #(
	parameter int FILTER_CYCLES = 10000
) (
	// Clock, reset and enable
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic clock_enable_i,
	// Safety side
	input wire logic safety_input_a_i,
	input wire logic safety_input_b_i,
	input wire logic gate_enable_o,
	input wire logic torque_off_state_o,
	input wire logic channel_mismatch_fault_o,
	// Bus answers
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking cb @(posedge clock_i); endclocking
	// Frozen cycles carry no timing promise, so attempts spanning them are dropped
	default disable iff (rst_i || !clock_enable_i);
	property p_exclusive; gate_enable_o |-> !torque_off_state_o; endproperty
	a_exclusive: assert property (p_exclusive) else $error("gate on in torque off");
	property p_open_stop;
		$fell(safety_input_a_i && safety_input_b_i) ##1 !(safety_input_a_i && safety_input_b_i) [*5] |-> !gate_enable_o;
	endproperty
	a_open_stop: assert property (p_open_stop) else $error("gate still on after opening");
	property p_both_open;
		(!safety_input_a_i && !safety_input_b_i) [*8] |-> torque_off_state_o && !channel_mismatch_fault_o;
	endproperty
	a_both_open: assert property (p_both_open) else $error("both open not reported");
	property p_mismatch; channel_mismatch_fault_o |-> torque_off_state_o && !gate_enable_o; endproperty
	a_mismatch: assert property (p_mismatch) else $error("mismatch without torque off");
	property p_gate_rise;
		$rose(gate_enable_o) |-> safety_input_a_i && safety_input_b_i && $past(safety_input_a_i, 4)
			&& $past(safety_input_b_i, 4);
	endproperty
	a_gate_rise: assert property (p_gate_rise) else $error("gate rose without closed channels");
	property p_release; $fell(torque_off_state_o) |-> !gate_enable_o; endproperty
	a_release: assert property (p_release) else $error("gate on at release");
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read answer dropped");
	property p_bdone; $fell(s_axi_bvalid) |-> $past(s_axi_bready); endproperty
	a_bdone: assert property (p_bdone) else $error("write answer withdrawn without bready");
	property p_rdone; $fell(s_axi_rvalid) |-> $past(s_axi_rready); endproperty
	a_rdone: assert property (p_rdone) else $error("read answer withdrawn without rready");
endmodule // torque_off_monitor_sva
bind torque_off_monitor torque_off_monitor_sva #(.FILTER_CYCLES(FILTER_CYCLES)) u_torque_off_monitor_sva (
	.clock_i, .rst_i, .clock_enable_i,
	.safety_input_a_i, .safety_input_b_i, .gate_enable_o, .torque_off_state_o, .channel_mismatch_fault_o,
	.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

/* File: tb/safety_relay_model.sv */
// Safety relay model driving both channels
`timescale 1ns/1ps
module safety_relay_model #(
	parameter int MIN_OPEN_CYCLES = 300000
) (
	// Clock
	input wire logic clock_i,
	// Requests and pins, pins high while closed
	input wire logic [1:0] open_request_i,
	output logic safety_input_a_o,
	output logic safety_input_b_o
);
	int hold_count [2];
	// Short requests are stretched, so a brief opening is not missed
	always_ff @(posedge clock_i)
	begin
		for (int i = 0; i < 2; i++)
		begin
			if (open_request_i[i])
				hold_count[i] <= MIN_OPEN_CYCLES;
			else if (hold_count[i] != 0)
				hold_count[i] <= hold_count[i] - 1;
		end
	end
	assign safety_input_a_o = (hold_count[0] == 0);
	assign safety_input_b_o = (hold_count[1] == 0);
endmodule // safety_relay_model

/* File: tb/tb_top.sv */
// Self-checking bench for the torque off monitor
`timescale 1ns/1ps
`include "sto_map.svh"
module tb_top;
	import sto_pkg::*;
	logic clock_i = 1'b0, rst_i = 1'b1, clock_enable_i = 1'b1, run_command_i = 1'b0;
	logic safety_input_a_i, safety_input_b_i, gate_enable_o, torque_off_state_o, channel_mismatch_fault_o;
	logic multifunction_digital_output_o, irq_o, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, open_req = 2'b00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	int fails = 0, cmp_count = 0, cycles = 0;
	torque_off_monitor #(.FILTER_CYCLES(4)) u_torque_off_monitor (.clock_i, .rst_i, .clock_enable_i, .safety_input_a_i,
		.safety_input_b_i, .run_command_i, .gate_enable_o, .torque_off_state_o, .channel_mismatch_fault_o,
		.multifunction_digital_output_o, .irq_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	safety_relay_model #(.MIN_OPEN_CYCLES(20)) u_safety_relay_model (.clock_i, .open_request_i(open_req),
		.safety_input_a_o(safety_input_a_i), .safety_input_b_o(safety_input_b_i));
	always #5 clock_i = ~clock_i;
	task end_sim;
		if (fails == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clock_i)
	begin
		cycles++;
		if (cycles == 10000)
		begin
			fails++;
			end_sim();
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected at %0t ns: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	task axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
		@(posedge clock_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clock_i);
			if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
			if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
		@(posedge clock_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clock_i);
			if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		d = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task wait_release;
		int n;
		open_req <= 2'b00;
		run_command_i <= 1'b0;
		n = 0;
		while (torque_off_state_o !== 1'b0 && n < 100)
		begin
			@(posedge clock_i);
			n++;
		end
		chk(torque_off_state_o, 1'b0);
	endtask
	task t_regs;
		logic [31:0] d;
		logic [1:0] r;
		axi_read(`REG_CTRL, d, r);
		chk(d, `CTRL_RESET);
		chk(r, 2'b00);
		axi_read(12'h100, d, r);
		chk(r, 2'b10);
		axi_write(12'h100, 32'h0000_0001, r);
		chk(r, 2'b10);
	endtask
	task t_chan;
		for (int ch = 0; ch < 2; ch++)
		begin
			wait_release();
			run_command_i <= 1'b1;
			cyc(8);
			chk(gate_enable_o, 1'b1);
			open_req <= 2'b01 << ch;
			cyc(1);
			open_req <= 2'b00;
			cyc(7);
			chk(gate_enable_o, 1'b0);
			chk(channel_mismatch_fault_o, 1'b1);
			chk(multifunction_digital_output_o, 1'b0);
			cyc(40);
			chk(torque_off_state_o, 1'b1);
		end
		wait_release();
		cyc(8);
		chk(gate_enable_o, 1'b0);
	endtask
	task t_codes;
		logic [7:0] code;
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 3; i++)
		begin
			code = (i == 0) ? `FUNC_MONITOR : (i == 1) ? `FUNC_MONITOR_INV : 8'h22;
			axi_write(`REG_CTRL, {24'h00_0000, code}, r);
			cyc(3);
			chk(multifunction_digital_output_o, code == `FUNC_MONITOR_INV);
			if (i == 2)
			begin
				axi_read(`REG_IRQ_STATUS, d, r);
				chk(d[3], 1'b1);
			end
			open_req <= 2'b11;
			cyc(8);
			chk(multifunction_digital_output_o, code == `FUNC_MONITOR);
			chk(channel_mismatch_fault_o, 1'b0);
			wait_release();
		end
		axi_write(`REG_CTRL, `CTRL_RESET, r);
	endtask
	// Both channels open while frozen: nothing may move until the enable returns
	task t_freeze;
		wait_release();
		clock_enable_i <= 1'b0;
		open_req <= 2'b11;
		cyc(8);
		chk(torque_off_state_o, 1'b0);
		clock_enable_i <= 1'b1;
		cyc(8);
		chk(torque_off_state_o, 1'b1);
		wait_release();
	endtask
	task t_irq;
		logic [31:0] d;
		logic [1:0] r;
		axi_write(`REG_IRQ_CLEAR, 32'h0000_000f, r);
		axi_write(`REG_IRQ_ENABLE, 32'h0000_0001, r);
		cyc(2);
		chk(irq_o, 1'b0);
		open_req <= 2'b11;
		cyc(8);
		chk(irq_o, 1'b1);
		axi_read(`REG_IRQ_STATUS, d, r);
		chk(d[0], 1'b1);
		axi_read(`REG_STATUS, d, r);
		chk(d, 32'h0000_0014);
		axi_write(`REG_IRQ_ENABLE, 32'h0000_0000, r);
		cyc(2);
		chk(irq_o, 1'b0);
		axi_write(`REG_IRQ_ENABLE, 32'h0000_0001, r);
		cyc(2);
		chk(irq_o, 1'b1);
		wait_release();
		axi_write(`REG_IRQ_CLEAR, 32'h0000_0001, r);
		cyc(2);
		chk(irq_o, 1'b0);
		axi_read(`REG_IRQ_CLEAR, d, r);
		chk(d, 32'h0000_0000);
		open_req <= 2'b01;
		cyc(8);
		axi_read(`REG_IRQ_STATUS, d, r);
		chk(d[1], 1'b1);
		wait_release();
	endtask
	initial
	begin
		repeat (12) @(posedge clock_i);
		rst_i <= 1'b0;
		t_regs();
		t_chan();
		t_codes();
		t_freeze();
		t_irq();
		end_sim();
	end
endmodule // tb_top
